//--- design/prbs31_defs.vh
// Purpose: constants for the line-side prbs-31 test engine
// Assumes: byte-wide management registers on page 03h
// Notes: definitions only
`ifndef PRBS31_DEFS_VH
`define PRBS31_DEFS_VH

// management page and register offsets
`define PT_PAGE 8'h03
`define PT_CTRL_OFS 8'hb7
`define PT_CNT3_OFS 8'hb8
`define PT_CNT2_OFS 8'hb9
`define PT_CNT1_OFS 8'hba
`define PT_CNT0_OFS 8'hbb

// control register fields
`define PT_TX_EN_BIT 0
`define PT_RX_EN_BIT 1
`define PT_SYNC_BIT 4
`define PT_CLR_BIT 7
`define PT_CTRL_RW_MASK 8'h6f
`define PT_CTRL_RESET 8'h00

// pattern generator seed and checker thresholds
`define PT_SEED 31'h7fffffff
`define PT_LOCK_WORDS 8
`define PT_LOSS_ERRS 4

`endif

//--- design/prbs31_line_test_engine.v
// Purpose: prbs-31 payload generator and checker with error counter
// Assumes: management access port from the two-wire front end, one clock
// Notes: framing, overhead and fec run outside; payload words are flagged
//   by the framer, and only flagged words are replaced or checked
//   the error count is snapshotted on reading its top byte, so the host
//   must read the four count registers top byte first
//   lock needs eight clean words in a row; more than four wrong bits in a
//   word drops it again
//
// Contract
// - with tx enable (ctrl bit 0) set, payload words carry prbs-31, else normal payload.
// - overhead and fec words pass untouched so alarms and fec statistics stay valid.
// - with rx enable (ctrl bit 1) set, payload is checked, corrected data with fec on, raw with it off.
// - every mismatched payload bit while the checker is locked adds one to a saturating 32-bit error counter.
// - ctrl bit 4 reads 0 while the checker is locked and 1 otherwise.
// - writing 1 to ctrl bit 7 zeroes the counter and the bit returns to 0 by itself.
// - the count reads msb first across registers 0xb8 to 0xbb.
`timescale 1ns/10ps
`include "prbs31_defs.vh"

// data flow
//   tx: words from the framer side enter a two-entry buffer; a payload
//   word is swapped for the next eight generator bits on its way in, so
//   the buffer always holds exactly what the line will carry
//   tx: the generator steps only when a pattern word is accepted, which
//   keeps the sequence gapless across stalls of the far side
//   rx: the checker picks corrected or raw words by the fec switch and
//   looks only at words flagged as payload
//   rx: while hunting, the checker loads its state from the line, so any
//   phase of the sequence is found within four words; once tracking, it
//   runs on its own bits so a line error costs one count, not three
//   status: lock is a two-state machine, hunt and track
//   registers: control, then the count top byte to bottom byte
// hazards
//   a word with many wrong bits while hunting only restarts the run, it
//   is never counted; errors are counted only while tracking
//   the counter holds at all ones rather than wrap to a small value,
//   which would hide a badly broken link behind a harmless reading
//   the clear request lasts one cycle; errors arriving in that cycle
//   are loaded into the fresh count, not lost
//   a stall on the tx side never stalls the rx side; the two directions
//   share only the clock, the reset and the control register
//   overhead words pass both directions untouched, so alarms and fec
//   statistics downstream keep seeing a normal frame
//   limitation: the count registers are read-only; writes to them are
//   silently dropped

module prbs31_line_test_engine #(
  parameter W = 8,
  parameter LOCK_WORDS = `PT_LOCK_WORDS,
  parameter LOSS_ERRS = `PT_LOSS_ERRS
) (
  input wire mclk,
  input wire arst_n,
  // management register port
  input wire [7:0] mgmt_page,
  input wire [7:0] mgmt_addr,
  input wire mgmt_wr,
  input wire [7:0] mgmt_wdata,
  input wire mgmt_rd,
  output reg [7:0] mgmt_rdata,
  // transmit payload stream in
  input wire tx_in_valid,
  output wire tx_in_ready,
  input wire [W-1:0] tx_in_data,
  input wire tx_in_payload,
  // transmit stream out to the framer
  output wire tx_out_valid,
  input wire tx_out_ready,
  output wire [W-1:0] tx_out_data,
  output wire tx_out_payload,
  // receive stream from the deframer
  input wire rx_valid,
  input wire rx_payload,
  input wire [W-1:0] rx_raw_data,
  input wire [W-1:0] rx_corr_data,
  input wire fec_on,
  // status
  output wire rx_locked,
  output wire [31:0] err_count
);

  localparam CW = 8;

  // checker lock states
  localparam HUNT = 1'b0;
  localparam TRACK = 1'b1;

  // expected bits from a state, shifting in own bits or received bits
  function [W-1:0] prbs_bits;
    input [30:0] s;
    input [W-1:0] d;
    input use_d;
    integer i;
    reg [30:0] t;
    reg b;
    begin
      t = s;
      prbs_bits = {W{1'b0}};
      for (i = W - 1; i >= 0; i = i - 1) begin
        b = t[30] ^ t[27];
        prbs_bits[i] = b;
        t = {t[29:0], use_d ? d[i] : b};
      end
    end
  endfunction

  function [30:0] prbs_next;
    input [30:0] s;
    input [W-1:0] d;
    input use_d;
    integer i;
    reg b;
    begin
      prbs_next = s;
      for (i = W - 1; i >= 0; i = i - 1) begin
        b = prbs_next[30] ^ prbs_next[27];
        prbs_next = {prbs_next[29:0], use_d ? d[i] : b};
      end
    end
  endfunction

  function [CW-1:0] ones;
    input [W-1:0] v;
    integer i;
    begin
      ones = {CW{1'b0}};
      for (i = 0; i < W; i = i + 1)
        ones = ones + {{(CW-1){1'b0}}, v[i]};
    end
  endfunction

  // one decoder for every register access, so reads, writes and the
  // snapshot strobe can never disagree about what sits where
  function reg_hit;
    input [7:0] page;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      reg_hit = (page == `PT_PAGE) && (addr == ofs);
    end
  endfunction

  // control, generator, checker and counter state
  reg [7:0] ctrl_q;
  reg clr_q;
  reg [30:0] gen_q;
  reg [30:0] chk_q;
  reg lock_q;
  reg [7:0] run_q;
  reg [31:0] cnt_q;
  reg [23:0] snap_q;

  // control decode
  wire tx_en = ctrl_q[`PT_TX_EN_BIT];
  wire rx_en = ctrl_q[`PT_RX_EN_BIT];
  wire ctrl_wr = mgmt_wr && reg_hit(mgmt_page, mgmt_addr, `PT_CTRL_OFS);

  // two-entry buffer toward the framer; a full buffer drops tx_in_ready
  // so the sender waits instead of losing a word
  reg [W:0] buf_mem [0:1];
  reg wp_q;
  reg rp_q;
  reg [1:0] fill_q;
  wire push = tx_in_valid && tx_in_ready;
  wire pop = tx_out_valid && tx_out_ready;
  assign tx_in_ready = (fill_q != 2'd2);
  assign tx_out_valid = (fill_q != 2'd0);
  assign tx_out_data = buf_mem[rp_q][W-1:0];
  assign tx_out_payload = buf_mem[rp_q][W];

  // payload replaced by pattern, overhead and fec words left alone
  wire ins = tx_en && tx_in_payload;
  wire [W-1:0] gen_bits = prbs_bits(gen_q, {W{1'b0}}, 1'b0);
  wire [W-1:0] tx_word = ins ? gen_bits : tx_in_data;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      fill_q <= 2'd0;
      buf_mem[0] <= {(W+1){1'b0}};
      buf_mem[1] <= {(W+1){1'b0}};
    end else begin
      if (push) begin
        buf_mem[wp_q] <= {tx_in_payload, tx_word};
        wp_q <= ~wp_q;
      end
      if (pop)
        rp_q <= ~rp_q;
      if (push && !pop)
        fill_q <= fill_q + 2'd1;
      else if (pop && !push)
        fill_q <= fill_q - 2'd1;
    end
  end

  // generator advances only on accepted pattern words, so a stall
  // downstream never skips part of the sequence
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n)
      gen_q <= `PT_SEED;
    else if (push && ins)
      gen_q <= prbs_next(gen_q, {W{1'b0}}, 1'b0);
  end

  // checker input selection
  wire [W-1:0] rx_word = fec_on ? rx_corr_data : rx_raw_data;
  wire rx_take = rx_en && rx_valid && rx_payload;
  wire [W-1:0] exp_bits = prbs_bits(chk_q, rx_word, ~lock_q);
  wire [W-1:0] miss = rx_word ^ exp_bits;
  wire [CW-1:0] nerr = ones(miss);
  wire [31:0] add_errs = (rx_take && lock_q) ? {24'h000000, nerr} : 32'h0;

  // self-synchronising checker: while unlocked the state is loaded from
  // the line, after lock it free-runs so bit errors are not echoed
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      chk_q <= `PT_SEED;
      lock_q <= 1'b0;
      run_q <= 8'h00;
    end else if (!rx_en) begin
      lock_q <= 1'b0;
      run_q <= 8'h00;
    end else if (rx_take) begin
      chk_q <= prbs_next(chk_q, rx_word, ~lock_q);
      case (lock_q)
        HUNT: begin
          if (nerr != {CW{1'b0}})
            run_q <= 8'h00;
          else if (run_q == LOCK_WORDS - 1) begin
            lock_q <= TRACK;
            run_q <= 8'h00;
          end else
            run_q <= run_q + 8'h01;
        end
        TRACK: begin
          if (nerr > LOSS_ERRS)
            lock_q <= HUNT;
        end
        default: lock_q <= HUNT;
      endcase
    end
  end

  // saturating counter; errors in the clearing cycle are kept
  // the carry bit of the sum tells an overflow without a compare
  wire [32:0] sum = {1'b0, cnt_q} + {1'b0, add_errs};
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n)
      cnt_q <= 32'h00000000;
    else if (clr_q)
      cnt_q <= add_errs;
    else if (sum[32])
      cnt_q <= 32'hffffffff;
    else
      cnt_q <= sum[31:0];
  end

  // control register; clear bit is a one-cycle self-clearing request
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= `PT_CTRL_RESET;
      clr_q <= 1'b0;
    end else begin
      clr_q <= ctrl_wr && mgmt_wdata[`PT_CLR_BIT];
      if (ctrl_wr)
        ctrl_q <= mgmt_wdata & `PT_CTRL_RW_MASK;
    end
  end

  // reading the msb freezes the lower bytes so a count is read whole
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n)
      snap_q <= 24'h000000;
    else if (mgmt_rd && reg_hit(mgmt_page, mgmt_addr, `PT_CNT3_OFS))
      snap_q <= cnt_q[23:0];
  end

  // read multiplexer; other pages and unmapped offsets read as zero
  reg [7:0] rdata_d;
  always @* begin
    rdata_d = 8'h00;
    if (reg_hit(mgmt_page, mgmt_addr, `PT_CTRL_OFS))
      rdata_d = {clr_q, ctrl_q[6:5], ~lock_q, ctrl_q[3:0]};
    else if (reg_hit(mgmt_page, mgmt_addr, `PT_CNT3_OFS))
      rdata_d = cnt_q[31:24];
    else if (reg_hit(mgmt_page, mgmt_addr, `PT_CNT2_OFS))
      rdata_d = snap_q[23:16];
    else if (reg_hit(mgmt_page, mgmt_addr, `PT_CNT1_OFS))
      rdata_d = snap_q[15:8];
    else if (reg_hit(mgmt_page, mgmt_addr, `PT_CNT0_OFS))
      rdata_d = snap_q[7:0];
  end

  // read data, registered one cycle after the strobe and held until the
  // next read, so a slow front end can fetch it at leisure
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n)
      mgmt_rdata <= 8'h00;
    else if (mgmt_rd)
      mgmt_rdata <= rdata_d;
  end

  assign rx_locked = lock_q;
  assign err_count = cnt_q;

endmodule

//--- test/prbs31_checker.sv
// Purpose: port assertions for the prbs-31 test engine
// Assumes: one clock, async reset
// Notes: bound from the bench top
`timescale 1ns/10ps
module prbs31_checker #(
  parameter W = 8
) (
  input wire mclk,
  input wire arst_n,
  input wire [7:0] mgmt_page,
  input wire [7:0] mgmt_addr,
  input wire mgmt_wr,
  input wire [7:0] mgmt_wdata,
  input wire mgmt_rd,
  input wire [7:0] mgmt_rdata,
  input wire tx_in_valid,
  input wire tx_in_ready,
  input wire tx_out_valid,
  input wire tx_out_ready,
  input wire [W-1:0] tx_out_data,
  input wire rx_locked,
  input wire [31:0] err_count
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // decoded accesses on the test page
  wire pg = mgmt_page == 8'h03;
  wire clr_now = mgmt_wr && pg && mgmt_addr == 8'hb7 && mgmt_wdata[7];
  sequence ctrl_rd;
    mgmt_rd && pg && mgmt_addr == 8'hb7;
  endsequence
  sequence quiet2;
    (!rx_locked && !mgmt_wr)[*2];
  endsequence
  off_page_a: assert property (mgmt_rd && !pg |=> mgmt_rdata == 8'h00)
    else $error("off page read not zero");
  sync_bit_a: assert property (ctrl_rd |=> mgmt_rdata[4] == !$past(rx_locked))
    else $error("sync bit wrong");
  count_msb_a: assert property (mgmt_rd && pg && mgmt_addr == 8'hb8
    |=> mgmt_rdata == $past(err_count[31:24])) else $error("count msb wrong");
  clr_zero_a: assert property (clr_now |=> ##1 err_count <= 32'h8)
    else $error("count not cleared");
  self_clear_a: assert property (ctrl_rd ##0 !$past(clr_now)
    |=> !mgmt_rdata[7]) else $error("clear bit stuck");
  count_hold_a: assert property (quiet2 |=> $stable(err_count))
    else $error("count moved while unlocked");
  count_sat_a: assert property (err_count == 32'hffffffff && !$past(clr_now)
    |=> err_count == 32'hffffffff) else $error("count wrapped");
  stall_hold_a: assert property (tx_out_valid && !tx_out_ready
    |=> tx_out_valid && $stable(tx_out_data)) else $error("word lost on stall");
  push_out_a: assert property (tx_in_valid && tx_in_ready |=> tx_out_valid)
    else $error("pushed word not offered");
endmodule

//--- test/prbs31_far_end.sv
// Purpose: far-end peer that takes line words and sends them back
// Assumes: one clock shared with the engine
// Notes: flip corrupts raw data only, so fec hides it
`timescale 1ns/10ps
module prbs31_far_end (
  input wire mclk,
  input wire arst_n,
  input wire slow,
  input wire [7:0] flip,
  input wire tx_out_valid,
  input wire [7:0] tx_out_data,
  input wire tx_out_payload,
  output reg tx_out_ready,
  output reg rx_valid,
  output reg rx_payload,
  output reg [7:0] rx_raw_data,
  output reg [7:0] rx_corr_data
);
  reg [2:0] tick_q;
  wire acc = tx_out_valid && tx_out_ready;
  // stalls two cycles in four when slow; idle lines show inverted data
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tick_q <= 3'h0;
      tx_out_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_payload <= 1'b0;
      rx_raw_data <= 8'h00;
      rx_corr_data <= 8'h00;
    end else begin
      tick_q <= tick_q + 3'h1;
      tx_out_ready <= !slow || tick_q[1];
      rx_valid <= acc;
      rx_payload <= tx_out_payload;
      rx_raw_data <= acc ? tx_out_data ^ flip : ~rx_raw_data;
      rx_corr_data <= acc ? tx_out_data : ~rx_corr_data;
    end
  end
endmodule

//--- test/test_prbs31_line_test_engine.sv
// Purpose: self-checking bench for the prbs-31 test engine
// Assumes: the far end loops line words back to the receiver
// Notes: drivers queue expected values, monitors compare them
`timescale 1ns/10ps
module test_prbs31_line_test_engine;
  reg mclk = 1'b0;
  reg arst_n = 1'b0;
  reg [7:0] mgmt_page = 8'h03, mgmt_addr = 8'h00, mgmt_wdata = 8'h00;
  reg mgmt_wr = 1'b0, mgmt_rd = 1'b0, rd_q = 1'b0;
  reg tx_in_valid = 1'b0, tx_in_payload = 1'b0, fec_on = 1'b0, slow = 1'b0;
  reg [7:0] tx_in_data = 8'h00, flip = 8'h00, ctrl = 8'h00;
  reg [30:0] gen_q = 31'h7fffffff;
  wire tx_in_ready, tx_out_valid, tx_out_ready, tx_out_payload;
  wire rx_valid, rx_payload, rx_locked;
  wire [7:0] mgmt_rdata, tx_out_data, rx_raw_data, rx_corr_data;
  wire [31:0] err_count;
  reg [7:0] rq[$], tq[$], pq[$];
  integer err_total = 0, checks = 0, cyc = 0, i;
  always #12.5 mclk = ~mclk;
  prbs31_line_test_engine #(.W(8)) prbs31_line_test_engine_i (.mclk, .arst_n,
    .mgmt_page, .mgmt_addr, .mgmt_wr, .mgmt_wdata, .mgmt_rd, .mgmt_rdata,
    .tx_in_valid, .tx_in_ready, .tx_in_data, .tx_in_payload, .tx_out_valid,
    .tx_out_ready, .tx_out_data, .tx_out_payload, .rx_valid, .rx_payload,
    .rx_raw_data, .rx_corr_data, .fec_on, .rx_locked, .err_count);
  prbs31_far_end prbs31_far_end_i (.mclk, .arst_n, .slow, .flip, .tx_out_valid,
    .tx_out_data, .tx_out_payload, .tx_out_ready, .rx_valid, .rx_payload,
    .rx_raw_data, .rx_corr_data);
  task cmp(input string what, input [7:0] exp, input [7:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // oldest note against each result; cycle ceiling cuts a hang
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc > 20000) begin
      err_total = err_total + 1;
      report_and_stop;
    end
    rd_q <= mgmt_rd;
    if (rd_q) cmp("register", rq.pop_front(), mgmt_rdata);
    if (tx_out_valid && tx_out_ready) begin
      cmp("tx word", tq.pop_front(), tx_out_data);
      cmp("payload", pq.pop_front(), {7'h00, tx_out_payload});
    end
  end
  // strobe held one cycle, sampled at the next edge
  task bus(input [7:0] p, input [7:0] a, input [7:0] d, input w);
    mgmt_page <= p;
    mgmt_addr <= a;
    mgmt_wdata <= d;
    mgmt_wr <= w;
    mgmt_rd <= !w;
    tx_in_valid <= 1'b0;
    @(posedge mclk);
    if (w && a == 8'hb7) ctrl = d & 8'h6f;
  endtask
  task rd(input [7:0] p, input [7:0] a, input [7:0] e);
    rq.push_back(e);
    bus(p, a, 8'h00, 1'b0);
  endtask
  task rdcnt(input [31:0] e);
    for (i = 3; i >= 0; i--) begin
      rd(8'h03, 8'hbb - i, e[i*8 +: 8]);
      cmp("count port", e[i*8 +: 8], err_count[i*8 +: 8]);
    end
  endtask
  // payload words with tx enable take the next eight generator bits
  task send(input [7:0] d, input p);
    integer k;
    mgmt_rd <= 1'b0;
    mgmt_wr <= 1'b0;
    tx_in_valid <= 1'b1;
    tx_in_data <= d;
    tx_in_payload <= p;
    @(posedge mclk iff tx_in_ready);
    for (k = 0; k < 8 && ctrl[0] && p; k++) begin
      d = {d[6:0], gen_q[30] ^ gen_q[27]};
      gen_q = {gen_q[29:0], gen_q[30] ^ gen_q[27]};
    end
    tq.push_back(d);
    pq.push_back({7'h00, p});
  endtask
  task idle(input integer n);
    mgmt_rd <= 1'b0;
    mgmt_wr <= 1'b0;
    tx_in_valid <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask
  initial begin
    i = $urandom(32'h4c5505c2);
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    rd(8'h03, 8'hb7, 8'h10);
    bus(8'h03, 8'hb7, 8'h6c, 1'b1);
    bus(8'h03, 8'hbb, 8'h55, 1'b1);
    rd(8'h03, 8'hb7, 8'h7c);
    rd(8'h02, 8'hb7, 8'h00);
    rdcnt(32'h0);
    $display("registers done");
    slow <= 1'b1;
    for (int j = 0; j < 24; j++) send(8'($urandom), 1'($urandom));
    idle(12);
    $display("pass-through done");
    slow <= 1'b0;
    bus(8'h03, 8'hb7, 8'h03, 1'b1);
    for (int j = 0; j < 12; j++) send(8'($urandom), 1'b1);
    idle(6);
    rd(8'h03, 8'hb7, 8'h03);
    cmp("lock", 8'h01, {7'h00, rx_locked});
    flip <= 8'h01;
    send(8'($urandom), 1'b1);
    idle(6);
    flip <= 8'hff;
    fec_on <= 1'b1;
    send(8'($urandom), 1'b1);
    idle(6);
    rdcnt(32'h1);
    $display("checker done");
    bus(8'h03, 8'hb7, 8'h83, 1'b1);
    idle(4);
    rd(8'h03, 8'hb7, 8'h03);
    rdcnt(32'h0);
    fec_on <= 1'b0;
    send(8'($urandom), 1'b1);
    idle(6);
    rd(8'h03, 8'hb7, 8'h13);
    cmp("lock", 8'h00, {7'h00, rx_locked});
    rdcnt(32'h8);
    idle(4);
    $display("clear and loss done");
    report_and_stop;
  end
endmodule
bind prbs31_line_test_engine prbs31_checker #(.W(W)) prbs31_checker_i (.mclk,
  .arst_n, .mgmt_page, .mgmt_addr, .mgmt_wr, .mgmt_wdata, .mgmt_rd,
  .mgmt_rdata, .tx_in_valid, .tx_in_ready, .tx_out_valid, .tx_out_ready,
  .tx_out_data, .rx_locked, .err_count);
